/* File: inc/rdi_pkg.sv */
// ***************************************************************
// Reset and identification constants
// ***************************************************************
package rdi_pkg;

    localparam int ADDR_W = 12;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADDR_ID   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_CFG  = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_REV  = 12'h100;

    // Pin configuration register layout.
    localparam int              CFG_W        = 4;
    localparam int              CFG_MIC_DIG  = 0;
    localparam int              CFG_PD_OFF   = 1;
    localparam int              CFG_PU_OFF   = 2;
    localparam int              CFG_SD_OFF   = 3;
    localparam logic [CFG_W-1:0] CFG_RST     = 4'h0;

    // Status register layout.
    localparam int STAT_RUN      = 0;
    localparam int STAT_ANA_GOOD = 1;
    localparam int STAT_CORE_GOOD = 2;

    // Revision register layout.
    localparam int CUST_LSB = 8;
    localparam int SREV_LSB = 0;

    // Power-on reset period.
    localparam int TPOR_NS   = 100;
    localparam int CLK_NS    = 4;
    localparam int TPOR_CYC  = (TPOR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = $clog2(TPOR_CYC + 1);

    typedef struct packed {
        logic spk_cfg_pullup;
        logic reg1_en_pulldown;
        logic reg2_en_pulldown;
        logic bus_addr_pulldown;
        logic main_clock_in_two_pulldown;
        logic aif2_pulldown;
        logic aif3_pulldown;
        logic sdout_drive;
        logic mic_digital_sel;
    } rdi_pins_t;

    localparam rdi_pins_t PINS_RST = '{
        spk_cfg_pullup:             1'b1,
        reg1_en_pulldown:           1'b1,
        reg2_en_pulldown:           1'b1,
        bus_addr_pulldown:          1'b1,
        main_clock_in_two_pulldown: 1'b1,
        aif2_pulldown:              1'b1,
        aif3_pulldown:              1'b1,
        sdout_drive:                1'b1,
        mic_digital_sel:            1'b0
    };

    typedef struct packed {
        logic             ana_s1;
        logic             ana_s2;
        logic             core_s1;
        logic             core_s2;
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic [CFG_W-1:0] cfg;
        logic             pready;
        logic [31:0]      prdata;
        logic             pslverr;
        logic             swrst;
        rdi_pins_t        pins;
    } rdi_state_t;

endpackage

/* File: core/rdi_top.sv */
`timescale 1ns/1ns
// How it works
// - Internal reset held low while either supply monitor reports low.
// - Bus writes are discarded while the internal reset is low.
// - On release all registers hold defaults and writes are accepted.
// - Reset stays low for at least 100 ns after both supplies are good.
// - Reset falls on the third clock edge after either supply reports below threshold.
// - Pins take their pull-up, pull-down and drive states after reset.
// - Software reset applies the same pin states as power-on reset.
// - Shared mic pin selects the analogue input after reset.
// - Reading address zero returns the fixed 16-bit identity code.
// - Any write to address zero resets all control registers.
// - Revision register gives customer code 15:8 and silicon revision 3:0.
module rdi_top
    import rdi_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID        = 16'h5a5a, // Arbitrary value.
    parameter logic [7:0]  CUSTOMER_CODE    = 8'h00,    // Arbitrary value.
    parameter logic [3:0]  SILICON_REVISION = 4'h0      // Arbitrary value.
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              analogue_supply_two_good,
    input  wire logic              core_supply_good,
    output logic                   core_reset_n,
    output logic                   soft_reset_pulse,
    output rdi_pins_t              pin_state
);

    // The count starts at zero, so the last counted value is one below the period.
    localparam logic [CNT_W-1:0] TPOR_LAST = CNT_W'(TPOR_CYC - 1);

    rdi_state_t s_q;
    rdi_state_t s_d;
    logic       good;
    logic       acc;
    logic       wr_done;

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        s_d         = s_q;
        s_d.ana_s1  = analogue_supply_two_good;
        s_d.ana_s2  = s_q.ana_s1;
        s_d.core_s1 = core_supply_good;
        s_d.core_s2 = s_q.core_s1;
        s_d.swrst   = 1'b0;
        good        = s_q.ana_s2 & s_q.core_s2;
        acc         = psel & penable & ~s_q.pready;
        wr_done     = psel & penable & s_q.pready & pwrite;

        // ***************************************************************
        // Supply monitors and power-on count
        // ***************************************************************
        // The count restarts whenever a synchronised monitor drops, so a supply
        // that bounces while ramping never shortens the minimum reset period.
        // Hold on low supply.
        if (!good) begin
            s_d.run = 1'b0;
            s_d.cnt = '0;
        end else if (!s_q.run) begin
            if (s_q.cnt == TPOR_LAST) begin
                s_d.run = 1'b1;
            end
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end

        // ***************************************************************
        // Register writes
        // ***************************************************************
        // Holding the configuration at its default for the whole reset means
        // release needs no separate clear step, and a write that arrives while
        // the supplies are still settling cannot leave a stray setting behind.
        // Defaults during reset.
        if (!s_q.run) begin
            s_d.cfg = CFG_RST;
        end else if (wr_done) begin
            case (paddr)
                ADDR_ID: begin
                    s_d.cfg   = CFG_RST;
                    s_d.swrst = 1'b1;
                end
                ADDR_CFG: begin
                    s_d.cfg = pwdata[CFG_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // ***************************************************************
        // Pin states
        // ***************************************************************
        // Pin states follow the configuration one cycle later, so a soft
        // reset lands on the pins in the cycle after the register clears.
        // Reset pin states.
        s_d.pins = PINS_RST;
        if (s_q.run) begin
            s_d.pins.mic_digital_sel            = s_q.cfg[CFG_MIC_DIG];
            s_d.pins.spk_cfg_pullup             = ~s_q.cfg[CFG_PU_OFF];
            s_d.pins.reg1_en_pulldown           = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.reg2_en_pulldown           = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.bus_addr_pulldown          = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.main_clock_in_two_pulldown = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.aif2_pulldown              = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.aif3_pulldown              = ~s_q.cfg[CFG_PD_OFF];
            s_d.pins.sdout_drive                = ~s_q.cfg[CFG_SD_OFF];
        end

        // ***************************************************************
        // Bus answer
        // ***************************************************************
        // One wait state keeps pready and prdata straight from flip-flops.
        // The price is one extra cycle on every access, which the host never notices.
        s_d.pready = acc;
        if (acc) begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
            case (paddr)
                ADDR_ID: begin
                    s_d.prdata[$bits(DEVICE_ID)-1:0] = DEVICE_ID;
                end
                ADDR_REV: begin
                    s_d.prdata[CUST_LSB+:$bits(CUSTOMER_CODE)]    = CUSTOMER_CODE;
                    s_d.prdata[SREV_LSB+:$bits(SILICON_REVISION)] = SILICON_REVISION;
                end
                ADDR_CFG: begin
                    s_d.prdata[CFG_W-1:0] = s_q.cfg;
                end
                ADDR_STAT: begin
                    s_d.prdata[STAT_RUN]       = s_q.run;
                    s_d.prdata[STAT_ANA_GOOD]  = s_q.ana_s2;
                    s_d.prdata[STAT_CORE_GOOD] = s_q.core_s2;
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end else begin
            s_d.pslverr = 1'b0;
        end
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    // Reset loads the pin defaults directly, so the pull and drive controls
    // never pass through an undefined state while the supplies ramp.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q      <= '0;
            s_q.pins <= PINS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign pready           = s_q.pready;
    assign prdata           = s_q.prdata;
    assign pslverr          = s_q.pslverr;
    assign core_reset_n     = s_q.run;
    assign soft_reset_pulse = s_q.swrst;
    assign pin_state        = s_q.pins;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus checks look at the completing cycle, where pready stands for one
    // cycle; that is where a write lands and where the read data is valid.

    AST_HOLD_LOW: assert property (
        !(s_q.ana_s2 && s_q.core_s2) |=> !core_reset_n [*2]
    ) else $error("Reset released while a supply is low.");

    AST_PDOWN: assert property (
        $fell(core_supply_good) && core_reset_n |-> ##[1:3] !core_reset_n
    ) else $error("Reset not asserted on power down.");

    AST_TPOR: assert property (
        $rose(core_reset_n) |-> $past(s_q.ana_s2, 25) && $past(s_q.core_s2, 25)
    ) else $error("Reset released before the minimum period.");

    AST_WR_DROP: assert property (
        !core_reset_n && psel && penable && pready && pwrite |=> s_q.cfg == CFG_RST
    ) else $error("Write accepted during reset.");

    AST_DEFAULTS: assert property (
        $rose(core_reset_n) |-> s_q.cfg == CFG_RST ##1 pin_state == PINS_RST
    ) else $error("Registers not at default on release.");

    AST_PINS: assert property (
        !core_reset_n |=> pin_state == PINS_RST
    ) else $error("Pins not in reset state.");

    AST_SWRST: assert property (
        core_reset_n && psel && penable && pready && pwrite && paddr == ADDR_ID
        |=> soft_reset_pulse && s_q.cfg == CFG_RST
    ) else $error("Software reset did not clear registers.");

    AST_SW_PINS: assert property (
        soft_reset_pulse && core_reset_n |=> pin_state == PINS_RST
    ) else $error("Pins not reset after software reset.");

    AST_MIC: assert property (
        $rose(core_reset_n) |=> !pin_state.mic_digital_sel
    ) else $error("Mic pin not analogue after reset.");

    AST_ID: assert property (
        psel && penable && pready && !pwrite && paddr == ADDR_ID
        |-> prdata == {16'h0000, DEVICE_ID}
    ) else $error("Identity read wrong.");

    AST_REV: assert property (
        psel && penable && pready && paddr == ADDR_REV
        |-> prdata == {16'h0000, CUSTOMER_CODE, 4'h0, SILICON_REVISION}
    ) else $error("Revision read wrong.");

    AST_REV_RO: assert property (
        core_reset_n && psel && penable && pready && pwrite && paddr == ADDR_REV
        |=> $stable(s_q.cfg) && !soft_reset_pulse
    ) else $error("Revision write had an effect.");

    // ***************************************************************
    // Supply and count checks
    // ***************************************************************
    AST_PDOWN_ANA: assert property (
        $fell(analogue_supply_two_good) && core_reset_n |-> ##[1:3] !core_reset_n
    ) else $error("Reset not asserted on analogue supply loss.");

    AST_FALL_CAUSE: assert property (
        $fell(core_reset_n) |-> !($past(s_q.ana_s2) && $past(s_q.core_s2))
    ) else $error("Reset asserted with both supplies good.");

    AST_CNT_CLR: assert property (
        !(s_q.ana_s2 && s_q.core_s2) |=> s_q.cnt == '0
    ) else $error("Power-on count not restarted on a low supply.");

    AST_CNT_FULL: assert property (
        $rose(core_reset_n) |-> $past(s_q.cnt) == TPOR_LAST
    ) else $error("Reset released before the count completed.");

    // ***************************************************************
    // Register, pin and bus checks
    // ***************************************************************
    AST_CFG_HELD: assert property (
        !core_reset_n && !$past(core_reset_n) |-> s_q.cfg == CFG_RST
    ) else $error("Configuration changed during reset.");

    AST_DROP_SW: assert property (
        !core_reset_n && psel && penable && pready && pwrite |=> !soft_reset_pulse
    ) else $error("Software reset taken during reset.");

    AST_WR_OK: assert property (
        core_reset_n && psel && penable && pready && pwrite && paddr == ADDR_CFG
        |=> s_q.cfg == $past(pwdata[CFG_W-1:0])
    ) else $error("Write not accepted after reset release.");

    AST_PINS_DRIVE: assert property (
        $rose(core_reset_n) |=> pin_state.sdout_drive && pin_state.spk_cfg_pullup
    ) else $error("Drive or pull-up missing after reset.");

    AST_SWRST_ONE: assert property (
        soft_reset_pulse |=> !soft_reset_pulse
    ) else $error("Software reset pulse longer than one cycle.");

    AST_SWRST_SRC: assert property (
        soft_reset_pulse |-> $past(core_reset_n) && $past(psel) && $past(penable)
        && $past(pready) && $past(pwrite) && $past(paddr) == ADDR_ID
    ) else $error("Software reset without a write to address zero.");

    AST_MIC_CFG: assert property (
        $past(core_reset_n) |-> pin_state.mic_digital_sel == $past(s_q.cfg[CFG_MIC_DIG])
    ) else $error("Mic pin function does not follow its setting.");

    AST_ID_OK: assert property (
        psel && penable && pready && paddr == ADDR_ID |-> !pslverr
    ) else $error("Identity access flagged as an error.");

    AST_REV_OK: assert property (
        psel && penable && pready && paddr == ADDR_REV |-> !pslverr
    ) else $error("Revision access flagged as an error.");

endmodule // rdi_top

/* File: tb/rdi_host.sv */
`timescale 1ns/1ns
// ***************************************************************
// Host processor model on the register bus
// ***************************************************************
module rdi_host
    import rdi_pkg::*;
(
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    input  wire logic              pready,
    input  wire logic [31:0]       prdata,
    input  wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // The request is held until pready is seen high; only the bench timeout ends a wait.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // rdi_host

/* File: tb/rdi_top_tb_top.sv */
`timescale 1ns/1ns
// ***************************************************************
// Self-checking bench
// ***************************************************************
module rdi_top_tb_top
    import rdi_pkg::*;
;
    localparam logic [15:0] ID = 16'h3c96; // Arbitrary value.
    localparam logic [7:0]  CC = 8'ha5;    // Arbitrary value.
    localparam logic [3:0]  SR = 4'h9;     // Arbitrary value.
    localparam logic [31:0] STAT_ALL =
        (32'h1 << STAT_RUN) | (32'h1 << STAT_ANA_GOOD) | (32'h1 << STAT_CORE_GOOD);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ana, core, crn, srp, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, d;
    rdi_pins_t         pins;
    int                fails, checked, cyc, n;

    rdi_top #(.DEVICE_ID(ID), .CUSTOMER_CODE(CC), .SILICON_REVISION(SR)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .analogue_supply_two_good(ana), .core_supply_good(core), .core_reset_n(crn),
        .soft_reset_pulse(srp), .pin_state(pins));
    rdi_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic rdi_pins_t exp_pins(input logic [3:0] c);
        return {~c[2], {6{~c[1]}}, ~c[3], c[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic power_up();
        n = 0;
        core <= 1'b1;
        ana  <= 1'b1;
        do begin @(posedge pclk); #1; n++; end while (crn !== 1'b1 && n < 60);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h871a));
        presetn = 1'b0;
        ana = 1'b0;
        core = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        h.xfer(1'b1, ADDR_CFG, 32'hf, rd, er);
        h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
        chk(rd, 32'h0, "cfg write in reset");
        chk(crn, 1'b0, "reset held");
        h.xfer(1'b0, ADDR_ID, 32'h0, rd, er);
        chk(rd, {16'h0, ID}, "id read");
        chk(er, 1'b0, "id read error flag");
        h.xfer(1'b0, ADDR_STAT, 32'h0, rd, er);
        chk(rd, 32'h0, "status in reset");
        $display("test hold done");
        ana <= 1'b1;
        repeat ($urandom_range(3, 9)) @(posedge pclk);
        #1 chk(crn, 1'b0, "reset with one supply");
        @(posedge pclk);
        power_up();
        // release only after the power-on period
        chk(n, TPOR_CYC + 2, "release edge count");
        chk(pins, PINS_RST, "pins after reset");
        h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
        chk(rd, {28'h0, CFG_RST}, "cfg default");
        h.xfer(1'b0, ADDR_STAT, 32'h0, rd, er);
        chk(rd, STAT_ALL, "status running");
        $display("test power up done");
        repeat (4) begin
            d = $urandom;
            h.xfer(1'b1, ADDR_CFG, d, rd, er);
            h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
            chk(rd, {28'h0, d[3:0]}, "cfg readback");
            chk(pins, exp_pins(d[3:0]), "pins follow cfg");
        end
        h.xfer(1'b1, ADDR_CFG, 32'hf, rd, er);
        h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
        chk(pins, exp_pins(4'hf), "pins before soft reset");
        h.xfer(1'b1, ADDR_ID, $urandom, rd, er);
        n = 0;
        repeat (4) begin #1 n += srp; @(posedge pclk); end
        chk(n, 1, "soft reset pulse");
        chk(pins, PINS_RST, "pins after soft reset");
        h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
        chk(rd, {28'h0, CFG_RST}, "cfg after soft reset");
        $display("test soft reset done");
        for (int i = 0; i < 2; i++) begin
            if (i == 1) h.xfer(1'b1, ADDR_REV, $urandom, rd, er);
            h.xfer(1'b0, ADDR_REV, 32'h0, rd, er);
            chk(rd, {16'h0, CC, 4'h0, SR}, "revision read");
        end
        h.xfer(1'b0, 12'h0fc, 32'h0, rd, er);
        chk(er, 1'b1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        $display("test revision done");
        h.xfer(1'b1, ADDR_CFG, 32'h5, rd, er);
        if ($urandom_range(0, 1)) ana <= 1'b0; else core <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk(crn, 1'b0, "reset on supply loss");
        h.xfer(1'b1, ADDR_CFG, 32'ha, rd, er);
        chk(pins, PINS_RST, "pins on supply loss");
        power_up();
        chk(n, TPOR_CYC + 2, "release after supply loss");
        h.xfer(1'b0, ADDR_CFG, 32'h0, rd, er);
        chk(rd, {28'h0, CFG_RST}, "cfg after supply loss");
        $display("test power down done");
        summarize();
    end
endmodule // rdi_top_tb_top
